// >>> ppg_core.sv
// Purpose: 16-bit up counter with duty and period compare driving a pulse pin
// Assumes: byte writes are single-cycle strobes on sys_clk; the external count
//          clock is a slow pin sampled into sys_clk
// Notes:   source clock selection is an 8-step prescaler of sys_clk or the pin
`include "ppg_map.svh"
`timescale 1ns/1ps
`default_nettype none
// Function
// [R1] run bit counts selected source edges
// [R2] duty match inverts output per initial level
// [R3] duty match pulses duty interrupt
// [R4] period match returns output to initial
// [R5] period match pulses interrupt, clears counter
// [R6] run cleared stops and clears counter
// [R7] stopped timer drives initial level
// [R8] external clock slow, levels two cycles
// [R9] buffered running commit loads shadow only
// [R10] buffered period match copies shadow active
// [R11] buffered stopped commit loads both
// [R12] unbuffered commit updates active at once
// [R13] value below count waits for wrap
// [R14] equal value matches right after write
// [R15] reads return last written values
// [R16] buffer enable one selects buffering
// [R17] high byte upper, low byte lower
// [R18] software writes duty high byte last
// [R19] initial level bit sets idle level
// [R20] counter wraps FFFF to 0000
// [R21] interrupts are one-cycle pulses per match
module ppg_core
#(
   parameter int TCK_W = `PPG_TCK_W
)
(
   input  wire  logic                 sys_clk,
   input  wire  logic                 nrst,
   input  wire  logic                 cascade_run,
   input  wire  logic                 output_initial_level,
   input  wire  logic                 buffer_enable,
   input  wire  logic                 external_select,
   input  wire  logic [TCK_W-1:0]     clock_select,
   input  wire  logic                 external_count_clock_pin,
   input  wire  logic [7:0]           wr_data,
   input  wire  logic                 wr_period_low_byte,
   input  wire  logic                 wr_period_high_byte,
   input  wire  logic                 wr_duty_low_byte,
   input  wire  logic                 wr_duty_high_byte,
   output var   ppg_pkg::ppg_cmp_s    rd_compare,
   output var   ppg_pkg::ppg_word_t   count_value,
   output var   logic                 pulse_output_pin,
   output var   logic                 duty_match_irq,
   output var   logic                 period_match_irq
);
   import ppg_pkg::*;

   // =====================================================================
   // source clock
   // =====================================================================
   logic       ext_meta_reg;
   logic       ext_sync_reg;
   logic       ext_last_reg;
   logic [7:0] div_reg;
   logic [7:0] div_next;
   logic [7:0] div_rise;
   wire        ext_tick;
   wire        int_tick;
   wire        src_tick;

   // the pin is two-flop synchronised; it must stay well below sys_clk/2
   assign ext_tick = ext_sync_reg & ~ext_last_reg;                    // [R8]
   assign div_next = div_reg + 8'h01;
   assign div_rise = div_next & ~div_reg;
   // setting 7 is the full rate; lower settings divide by powers of two
   assign int_tick = (clock_select == TCK_W'(7)) ? 1'b1
                   : div_rise[3'(6 - 32'(clock_select))];
   assign src_tick = external_select ? ext_tick : int_tick;

   always_ff @(posedge sys_clk)
   begin
      if (!nrst)
      begin
         ext_meta_reg <= 1'b0;
         ext_sync_reg <= 1'b0;
         ext_last_reg <= 1'b0;
         div_reg      <= 8'h00;
      end
      else
      begin
         ext_meta_reg <= external_count_clock_pin;
         ext_sync_reg <= ext_meta_reg;
         ext_last_reg <= ext_sync_reg;
         div_reg      <= cascade_run ? div_next : 8'h00;
      end
   end

   // =====================================================================
   // compare registers
   // =====================================================================
   ppg_cmp_s  wr_reg;
   ppg_cmp_s  shadow_reg;
   ppg_cmp_s  active_reg;
   ppg_cmp_s  commit_val;
   ppg_word_t cnt_reg;
   ppg_word_t cnt_next;
   ppg_state_e st_reg;
   ppg_state_e st_next;
   logic      out_reg;
   wire       commit;
   wire       run_q;
   wire       duty_hit;
   wire       period_hit;
   wire       load_active;

   // high byte stands above low byte in each 16-bit value
   assign commit_val  = {wr_data, wr_reg.duty[7:0], wr_reg.period};       // [R17]
   // the duty high byte commits all four bytes together
   assign commit      = wr_duty_high_byte;                                // [R18]
   assign run_q       = (st_reg != PPG_IDLE);
   // compares are level-sensitive on the current count, so an equal value
   // loaded by a write hits on the next cycle, off the source grid
   assign duty_hit    = run_q && (st_reg == PPG_ACTIVE)
                        && (cnt_reg == active_reg.duty);                  // [R2] [R14]
   assign period_hit  = run_q && (cnt_reg == active_reg.period);          // [R4] [R14]
   // buffered: a running commit waits in the shadow for the period match
   assign load_active = commit && (!buffer_enable || !run_q);             // [R11] [R12] [R16]
   assign cnt_next    = cnt_reg + `PPG_CNT_ONE;                           // [R20]
   assign rd_compare  = shadow_reg;                                       // [R15]

   always_ff @(posedge sys_clk)
   begin
      if (!nrst)
      begin
         wr_reg     <= {`PPG_CMP_RST, `PPG_CMP_RST};
         shadow_reg <= {`PPG_CMP_RST, `PPG_CMP_RST};
         active_reg <= {`PPG_CMP_RST, `PPG_CMP_RST};
      end
      else
      begin
         if (wr_period_low_byte)
            wr_reg.period[7:0] <= wr_data;
         if (wr_period_high_byte)
            wr_reg.period[15:8] <= wr_data;
         if (wr_duty_low_byte)
            wr_reg.duty[7:0] <= wr_data;
         if (commit)
         begin
            wr_reg.duty[15:8] <= wr_data;
            shadow_reg        <= commit_val;                              // [R9] [R15]
         end
         if (load_active)
            active_reg <= commit_val;                                     // [R11] [R12]
         else if (buffer_enable && period_hit)
            active_reg <= shadow_reg;                                     // [R10]
      end
   end

   // =====================================================================
   // counter and output
   // =====================================================================
   always_comb
   begin
      st_next = st_reg;
      case (st_reg)
         PPG_IDLE:
            if (cascade_run)
               st_next = PPG_ACTIVE;
         PPG_ACTIVE:
            if (!cascade_run)
               st_next = PPG_IDLE;
            else if (period_hit)
               st_next = PPG_ACTIVE;
            else if (duty_hit)
               st_next = PPG_DUTY;
         PPG_DUTY:
            if (!cascade_run)
               st_next = PPG_IDLE;
            else if (period_hit)
               st_next = PPG_ACTIVE;
         default:
            st_next = PPG_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk)
   begin
      if (!nrst)
      begin
         st_reg           <= PPG_IDLE;
         cnt_reg          <= `PPG_CNT_ZERO;
         out_reg          <= `PPG_OUT_RST;
         duty_match_irq   <= 1'b0;
         period_match_irq <= 1'b0;
      end
      else
      begin
         st_reg           <= st_next;
         duty_match_irq   <= duty_hit && !period_hit && cascade_run;     // [R3] [R21]
         period_match_irq <= period_hit && cascade_run;                  // [R5] [R21]
         if (!cascade_run)
            cnt_reg <= `PPG_CNT_ZERO;                                     // [R6]
         else if (period_hit)
            cnt_reg <= `PPG_CNT_ZERO;                                     // [R5]
         else if (run_q && src_tick)
            cnt_reg <= cnt_next;                                          // [R1] [R13] [R20]
         // the pin is the initial level, inverted only between the matches
         if (st_next == PPG_DUTY)
            out_reg <= ~output_initial_level;                             // [R2]
         else
            out_reg <= output_initial_level;                              // [R4] [R7] [R19]
      end
   end

   assign pulse_output_pin = out_reg;
   assign count_value      = cnt_reg;

   // =====================================================================
   // checks
   // =====================================================================
   sequence s_period_hit;
      period_hit && cascade_run;
   endsequence
   property p_period_clear;
      @(posedge sys_clk) disable iff (!nrst)
      s_period_hit |=> (cnt_reg == `PPG_CNT_ZERO) && period_match_irq;
   endproperty
   a_period_clear: assert property (p_period_clear)                      // [R5]
      else $error("period match did not clear counter or pulse irq");
   property p_duty_out;
      @(posedge sys_clk) disable iff (!nrst)
      (duty_hit && !period_hit && cascade_run) |=>
         (pulse_output_pin == !output_initial_level) && duty_match_irq;
   endproperty
   a_duty_out: assert property (p_duty_out)                              // [R2]
      else $error("duty match did not invert output");
   property p_stop_level;
      @(posedge sys_clk) disable iff (!nrst)
      !cascade_run |=> (cnt_reg == `PPG_CNT_ZERO)
         && (pulse_output_pin == $past(output_initial_level));
   endproperty
   a_stop_level: assert property (p_stop_level)                          // [R6]
      else $error("stopped timer not cleared or not at initial level");
   property p_irq_pulse;
      @(posedge sys_clk) disable iff (!nrst)
      period_match_irq |=> !period_match_irq;
   endproperty
   a_irq_pulse: assert property (p_irq_pulse)                            // [R21]
      else $error("period irq longer than one cycle");
   property p_duty_irq_pulse;
      @(posedge sys_clk) disable iff (!nrst)
      duty_match_irq |=> !duty_match_irq;
   endproperty
   a_duty_irq_pulse: assert property (p_duty_irq_pulse)                  // [R21]
      else $error("duty irq longer than one cycle");
   property p_count_step;
      @(posedge sys_clk) disable iff (!nrst)
      (run_q && cascade_run && src_tick && !period_hit) |=>
         (cnt_reg == $past(cnt_reg) + `PPG_CNT_ONE);
   endproperty
   a_count_step: assert property (p_count_step)                          // [R1]
      else $error("counter did not advance on source tick");
   property p_buffer_hold;
      @(posedge sys_clk) disable iff (!nrst)
      (commit && buffer_enable && run_q && !period_hit) |=>
         $stable(active_reg);
   endproperty
   a_buffer_hold: assert property (p_buffer_hold)                        // [R9]
      else $error("buffered running commit changed active values");
   property p_buffer_copy;
      @(posedge sys_clk) disable iff (!nrst)
      (buffer_enable && period_hit && !commit) |=>
         (active_reg == $past(shadow_reg));
   endproperty
   a_buffer_copy: assert property (p_buffer_copy)                        // [R10]
      else $error("period match did not copy shadow");
   property p_direct_load;
      @(posedge sys_clk) disable iff (!nrst)
      (commit && !buffer_enable) |=> (active_reg.duty[15:8] == $past(wr_data))
         && (rd_compare == active_reg);
   endproperty
   a_direct_load: assert property (p_direct_load)                        // [R12]
      else $error("unbuffered commit did not update active values");
endmodule : ppg_core
`default_nettype wire

// >>> ppg_map.svh
// Purpose: constants for the cascaded 16-bit pulse generator
// Assumes: included by ppg_pkg.sv and ppg_core.sv
// Notes:   definitions only
`ifndef PPG_MAP_SVH
`define PPG_MAP_SVH
`define PPG_CNT_W        16
`define PPG_CNT_ZERO     16'h0000
`define PPG_CNT_ONE      16'h0001
`define PPG_CMP_RST      16'h0000
`define PPG_OUT_RST      1'h0
`define PPG_TCK_W        3
`endif

// >>> ppg_pkg.sv
// Purpose: shared types for the cascaded 16-bit pulse generator
// Assumes: ppg_map.svh holds the numeric constants
// Notes:   compare pair travels as one struct
`default_nettype none
`include "ppg_map.svh"
package ppg_pkg;
   typedef logic [`PPG_CNT_W-1:0] ppg_word_t;
   typedef struct packed
   {
      ppg_word_t duty;
      ppg_word_t period;
   } ppg_cmp_s;
   typedef enum logic [1:0]
   {
      PPG_IDLE   = 2'h0,
      PPG_ACTIVE = 2'h1,
      PPG_DUTY   = 2'h3
   } ppg_state_e;
endpackage : ppg_pkg
`default_nettype wire

// >>> tb_ppg_core.sv
// Purpose: self-checking bench for ppg_core
// Assumes: the design carries its own assertions
// Notes:   table rows first, then buffered, wrap and reset cases
`timescale 1ns/1ps
`default_nettype none
module tb_ppg_core;
   import ppg_pkg::*;
   typedef struct {logic init; logic [2:0] cs; logic ext; ppg_word_t p; ppg_word_t d;} ppg_row_s;
   logic       sys_clk, nrst, cascade_run, init, buf_en, ext_sel, ext_pin, pin, dirq, pirq;
   logic [2:0] cs;
   logic [7:0] wr_data;
   logic [3:0] strb;
   ppg_cmp_s   rd_compare;
   ppg_word_t  count_value;
   int         mismatches, check_count, cyc, per, hi, nd, n, k;
   ppg_row_s   rows [5] = '{'{1'b0, 3'h7, 1'b0, 16'h0010, 16'h0004},
      '{1'b1, 3'h7, 1'b0, 16'h0008, 16'h0007}, '{1'b0, 3'h6, 1'b0, 16'h0006, 16'h0002},
      '{1'b1, 3'h5, 1'b0, 16'h0003, 16'h0001}, '{1'b0, 3'h7, 1'b1, 16'h0004, 16'h0001}};
   ppg_core dut_u (.sys_clk(sys_clk), .nrst(nrst), .cascade_run(cascade_run),
      .output_initial_level(init), .buffer_enable(buf_en), .external_select(ext_sel),
      .clock_select(cs), .external_count_clock_pin(ext_pin), .wr_data(wr_data),
      .wr_period_low_byte(strb[0]), .wr_period_high_byte(strb[1]),
      .wr_duty_low_byte(strb[2]), .wr_duty_high_byte(strb[3]), .rd_compare(rd_compare),
      .count_value(count_value), .pulse_output_pin(pin), .duty_match_irq(dirq),
      .period_match_irq(pirq));
   // ==========================================
   // clocks, timeout and helpers
   initial
   begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end
   // each level lasts four cycles, so one count per eight cycles
   initial
   begin
      ext_pin = 1'b0;
      forever
      begin
         repeat (4) @(posedge sys_clk);
         ext_pin <= ~ext_pin;
      end
   end
   always @(posedge sys_clk)
   begin
      cyc++;
      // the wrap case alone needs about 65600 cycles
      if (cyc == 90000)
      begin
         mismatches++;
         give_verdict();
      end
   end
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : give_verdict
   task automatic chk_word(input string what, input ppg_word_t exp, input ppg_word_t got);
      check_count++;
      if (got !== exp)
      begin
         mismatches++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask : chk_word
   task automatic chk_bit(input string what, input logic exp, input logic got);
      chk_word(what, {15'h0000, exp}, {15'h0000, got});
   endtask : chk_bit
   task automatic tick(input int c);
      repeat (c) @(posedge sys_clk);
      #1;
   endtask : tick
   // strobes go back to back; the duty high byte commits all four
   task automatic commit(input ppg_word_t p, input ppg_word_t d);
      logic [31:0] v;
      v = {d, p};
      for (int i = 0; i < 4; i++)
      begin
         @(posedge sys_clk);
         wr_data <= v[8*i +: 8];
         strb    <= 4'(4'h1 << i);
      end
      @(posedge sys_clk);
      strb <= 4'h0;
   endtask : commit
   task automatic wait_irq(output int c);
      c = 0;
      do
      begin
         tick(1);
         c++;
      end
      while (pirq !== 1'b1 && c < 70000);
   endtask : wait_irq
   // one whole period between two period interrupts
   task automatic measure();
      wait_irq(n);
      per = 0;
      hi = 0;
      nd = 0;
      do
      begin
         tick(1);
         per++;
         hi += (pin !== init);
         nd += (dirq === 1'b1);
      end
      while (pirq !== 1'b1 && per < 70000);
   endtask : measure
   task automatic start(input ppg_word_t p, input ppg_word_t d, input logic b);
      @(posedge sys_clk);
      cascade_run <= 1'b0;
      buf_en      <= b;
      commit(p, d);
      @(posedge sys_clk);
      cascade_run <= 1'b1;
   endtask : start
   // ==========================================
   // main sequence
   initial
   begin
      {nrst, cascade_run, init, buf_en, ext_sel, wr_data, strb} = '0;
      cs = 3'h7;
      repeat (8) @(posedge sys_clk);
      nrst <= 1'b1;
      tick(1);
      chk_word("reset_period", 16'h0000, rd_compare.period);
      chk_bit("reset_pin", 1'b0, pin);
      foreach (rows[i])
      begin
         @(posedge sys_clk);
         cascade_run <= 1'b0;
         init        <= rows[i].init;
         cs          <= rows[i].cs;
         ext_sel     <= rows[i].ext;
         tick(2);
         chk_bit("idle_pin", rows[i].init, pin);
         start(rows[i].p, rows[i].d, i[0]);
         tick(1);
         chk_word("period", rows[i].p, rd_compare.period);
         chk_word("duty", rows[i].d, rd_compare.duty);
         measure();
         k = rows[i].ext ? 8 : (1 << (7 - rows[i].cs));
         chk_word("high_cycles", 16'(k * (rows[i].p - rows[i].d)), 16'(hi));
         chk_bit("period_cycles", 1'b1, (k == 1) ? per == rows[i].p + 1 :
            (per == k * rows[i].p || per == k * (rows[i].p + 1)));
         chk_word("duty_irqs", 16'h0001, 16'(nd));
         tick(1);
         chk_bit("irq_width", 1'b0, pirq);
         @(posedge sys_clk);
         cascade_run <= 1'b0;
         tick(2);
         chk_word("stop_count", 16'h0000, count_value);
         chk_bit("stop_pin", rows[i].init, pin);
         $display("row %0d done", i);
      end
      @(posedge sys_clk);
      {init, ext_sel, cs} <= 5'h07;
      for (int b = 1; b >= 0; b--)
      begin
         start(16'h0010, 16'h0004, b[0]);
         wait_irq(n);
         commit(16'h0020, 16'h0008);
         tick(1);
         chk_word("rd_period", 16'h0020, rd_compare.period);
         wait_irq(n);
         chk_bit("old_period_kept", b[0], n < 16);
         measure();
         chk_word("new_period", 16'h0021, 16'(per));
         $display("update test buffered=%0d done", b);
      end
      start(16'h0040, 16'h0030, 1'b0);
      wait_irq(n);
      tick(32);
      commit(16'h0010, 16'h0008);
      wait_irq(n);
      chk_bit("wrap", 1'b1, n > 65000);
      $display("wrap test done");
      // slow source: an equal duty value written mid-tick hits at once
      @(posedge sys_clk);
      cs <= 3'h0;
      start(16'h0100, 16'h00F0, 1'b0);
      while (count_value !== 16'h0002)
         tick(1);
      commit(16'h0100, 16'h0002);
      tick(2);
      chk_bit("equal_hit_pin", 1'b1, pin);
      chk_word("equal_hit_count", 16'h0002, count_value);
      $display("equal value test done");
      @(posedge sys_clk);
      nrst <= 1'b0;
      tick(2);
      chk_word("rst_count", 16'h0000, count_value);
      chk_word("rst_duty", 16'h0000, rd_compare.duty);
      chk_bit("rst_pin", 1'b0, pin);
      @(posedge sys_clk);
      nrst        <= 1'b1;
      cascade_run <= 1'b0;
      tick(2);
      chk_word("release_count", 16'h0000, count_value);
      chk_bit("release_pin", 1'b0, pin);
      $display("reset test done");
      give_verdict();
   end
endmodule : tb_ppg_core
`default_nettype wire
